// *** core/stage_counter_pkg.sv ***
// shared constants and types for the stage and up/down counter block
package stage_counter_pkg;

    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SCAN = 8'h04;
    localparam logic [7:0] ADDR_STAGE_CLR = 8'h08;
    localparam logic [7:0] ADDR_STAGE_PRESET_K = 8'h0C;
    localparam logic [7:0] ADDR_STAGE_PRESET_V = 8'h10;
    localparam logic [7:0] ADDR_UDC_PRESET_K = 8'h14;
    localparam logic [7:0] ADDR_UDC_PRESET_V = 8'h18;
    localparam logic [7:0] ADDR_STAGE_VALUE = 8'h1C;
    localparam logic [7:0] ADDR_UDC_VALUE = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_DONE_WORD = 8'h28;
    localparam logic [7:0] ADDR_STAGE_LOC = 8'h2C;
    localparam logic [7:0] ADDR_UDC_LOC = 8'h30;

    // bcd limits and digit handling
    localparam int STAGE_DIGITS = 4;
    localparam int UDC_DIGITS = 8;
    localparam logic [15:0] STAGE_MAX = 16'h9999;
    localparam logic [31:0] UDC_MAX = 32'h9999_9999;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] DIGIT_ONE = 4'h1;

    // octal 1000 and octal 41140 as word addresses
    localparam logic [15:0] VALUE_WORD_BASE = 16'h0200;
    localparam logic [15:0] DONE_WORD_BASE = 16'h4260;

    // reset values
    localparam logic [15:0] STAGE_PRESET_RST = 16'h0000;
    localparam logic [31:0] UDC_PRESET_RST = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // status and clear command bit positions
    localparam int STATUS_STAGE_BIT = 0;
    localparam int STATUS_UDC_BIT = 1;
    localparam int CLR_CMD_BIT = 0;

    // program-driven inputs, one register
    typedef struct packed {
        logic udcPresetFromV;
        logic stagePresetFromV;
        logic udcReset;
        logic downIn;
        logic upIn;
        logic stageActive;
        logic stageIn;
    } ctrl_type;

    localparam ctrl_type CTRL_RST = '{default: 1'b0};

    // captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_phase_type;

    localparam ahb_phase_type PHASE_RST = '{valid: 1'b0, write: 1'b0, addr: 8'h00};

endpackage : stage_counter_pkg

// *** core/scan_edge.sv ***
// off-to-on detector that compares an input between consecutive scans
`timescale 1ns/1ns
`default_nettype none

module scan_edge (
    // clock and reset
    input wire logic mclk,
    input wire logic rstN,
    // scan strobe and sampled level
    input wire logic scan,
    input wire logic level,
    input wire logic gate,
    // result for this scan
    output logic rise
);

    logic prev_q;

    // the last scan's level, updated only when a scan runs
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            prev_q <= 1'b0;
        end else if (scan) begin
            prev_q <= level;
        end
    end

    assign rise = scan & level & ~prev_q & gate;

endmodule : scan_edge

`default_nettype wire

// *** core/stage_updown_counters.sv ***
// stage counter and up/down bcd counter behind an AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none

module stage_updown_counters #(
    parameter logic [7:0] STAGE_NUM = 8'h07,
    parameter logic [7:0] UDC_NUM = 8'h05
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // done bits
    output logic stageDone,
    output logic udcDone
);

    // up/down counter needs two counter numbers, all within octal 377
    if (UDC_NUM == 8'hFF || STAGE_NUM == UDC_NUM || STAGE_NUM == UDC_NUM + 8'h01) begin : gBadNum
        $error("counter numbers overlap or exceed range");
    end

    // reset release through two flip-flops
    logic rstMeta_q;
    logic rstN;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    // bcd step by one digit chain, up or down
    function automatic logic [31:0] bcdStep(input logic [31:0] v, input logic up);
        logic [31:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < stage_counter_pkg::UDC_DIGITS; i++) begin
            if (carry) begin
                if (up && r[4*i+:4] == stage_counter_pkg::DIGIT_MAX) begin
                    r[4*i+:4] = stage_counter_pkg::DIGIT_ZERO;
                end else if (!up && r[4*i+:4] == stage_counter_pkg::DIGIT_ZERO) begin
                    r[4*i+:4] = stage_counter_pkg::DIGIT_MAX;
                end else if (up) begin
                    r[4*i+:4] = r[4*i+:4] + stage_counter_pkg::DIGIT_ONE;
                    carry = 1'b0;
                end else begin
                    r[4*i+:4] = r[4*i+:4] - stage_counter_pkg::DIGIT_ONE;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcdStep

    // ---------------- bus slave ----------------
    stage_counter_pkg::ahb_phase_type phase_q;
    stage_counter_pkg::ctrl_type ctrl_q;
    logic [15:0] stagePresetK_q;
    logic [15:0] stagePresetV_q;
    logic [31:0] udcPresetK_q;
    logic [31:0] udcPresetV_q;
    logic [15:0] stageVal_q;
    logic [15:0] stageVal_d;
    logic [31:0] udcVal_q;
    logic [31:0] udcVal_d;
    logic stageDone_q;
    logic stageDone_d;
    logic udcDone_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    wire logic takeAddr = hsel & htrans[1] & hready;
    wire logic [7:0] aOff = haddr[7:0];
    wire logic inMap = (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'b00);
    wire logic wrEn = phase_q.valid & phase_q.write;
    wire logic wrCtrl = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_CTRL);
    wire logic scan = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_SCAN);
    wire logic stageClr = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_STAGE_CLR)
        & hwdata[stage_counter_pkg::CLR_CMD_BIT];
    wire logic wrSpk = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_STAGE_PRESET_K);
    wire logic wrSpv = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_STAGE_PRESET_V);
    wire logic wrUpk = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_UDC_PRESET_K);
    wire logic wrUpv = wrEn & (phase_q.addr == stage_counter_pkg::ADDR_UDC_PRESET_V);

    // address phase captured; only word offsets inside the map become active
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            phase_q <= stage_counter_pkg::PHASE_RST;
        end else if (hready) begin
            phase_q <= '{valid: takeAddr & inMap, write: hwrite, addr: aOff};
        end
    end

    // program-writable registers
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ctrl_q <= stage_counter_pkg::CTRL_RST;
            stagePresetK_q <= stage_counter_pkg::STAGE_PRESET_RST;
            stagePresetV_q <= stage_counter_pkg::STAGE_PRESET_RST;
            udcPresetK_q <= stage_counter_pkg::UDC_PRESET_RST;
            udcPresetV_q <= stage_counter_pkg::UDC_PRESET_RST;
        end else begin
            if (wrCtrl) ctrl_q <= hwdata[$bits(stage_counter_pkg::ctrl_type)-1:0];
            if (wrSpk) stagePresetK_q <= hwdata[15:0];
            if (wrSpv) stagePresetV_q <= hwdata[15:0];
            if (wrUpk) udcPresetK_q <= hwdata;
            if (wrUpv) udcPresetV_q <= hwdata;
        end
    end

    // preset source selected by the program
    wire logic [15:0] stagePreset = ctrl_q.stagePresetFromV ? stagePresetV_q : stagePresetK_q;
    wire logic [31:0] udcPreset = ctrl_q.udcPresetFromV ? udcPresetV_q : udcPresetK_q;

    // ---------------- stage counter ----------------
    logic stageActivePrev_q;
    logic stageRise;
    logic upRise;
    logic downRise;

    // stage active flag as seen on the previous scan
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            stageActivePrev_q <= 1'b0;
        end else if (scan) begin
            stageActivePrev_q <= ctrl_q.stageActive;
        end
    end

    scan_edge stageEdge (
        .mclk(mclk),
        .rstN(rstN),
        .scan(scan),
        .level(ctrl_q.stageIn),
        .gate(stageActivePrev_q),
        .rise(stageRise)
    );

    wire logic stageAtMax = (stageVal_q == stage_counter_pkg::STAGE_MAX);
    wire logic [31:0] stageStep = bcdStep({16'h0000, stageVal_q}, 1'b1);
    wire logic [15:0] stageInc = stageStep[15:0];
    wire logic stageGe = (stageVal_q >= stagePreset);

    // the value persists across scans; only the clear command zeroes it
    always_comb begin
        stageVal_d = stageVal_q;
        stageDone_d = stageDone_q | stageGe;
        if (stageClr) begin
            stageVal_d = 16'h0000;
            stageDone_d = 1'b0;
        end else if (stageRise && !stageAtMax) begin
            stageVal_d = stageInc;
        end
    end

    // ---------------- up/down counter ----------------
    scan_edge upEdge (
        .mclk(mclk),
        .rstN(rstN),
        .scan(scan),
        .level(ctrl_q.upIn),
        .gate(~ctrl_q.downIn),
        .rise(upRise)
    );

    scan_edge downEdge (
        .mclk(mclk),
        .rstN(rstN),
        .scan(scan),
        .level(ctrl_q.downIn),
        .gate(~ctrl_q.upIn),
        .rise(downRise)
    );

    wire logic udcAtMax = (udcVal_q == stage_counter_pkg::UDC_MAX);
    wire logic udcAtZero = (udcVal_q == 32'h0000_0000);
    wire logic udcGe = (udcVal_q >= udcPreset);
    wire logic [31:0] udcInc = bcdStep(udcVal_q, 1'b1);
    wire logic [31:0] udcDec = bcdStep(udcVal_q, 1'b0);

    // reset is a level sampled at each scan, so it holds zero scan after scan
    always_comb begin
        udcVal_d = udcVal_q;
        if (scan && ctrl_q.udcReset) begin
            udcVal_d = 32'h0000_0000;
        end else if (upRise && !udcAtMax) begin
            udcVal_d = udcInc;
        end else if (downRise && !udcAtZero) begin
            udcVal_d = udcDec;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            stageVal_q <= 16'h0000;
            stageDone_q <= 1'b0;
            udcVal_q <= 32'h0000_0000;
            udcDone_q <= 1'b0;
        end else begin
            stageVal_q <= stageVal_d;
            stageDone_q <= stageDone_d;
            udcVal_q <= udcVal_d;
            udcDone_q <= udcGe;
        end
    end

    // ---------------- read side ----------------
    wire logic [15:0] stageValAddr = stage_counter_pkg::VALUE_WORD_BASE + {8'h00, STAGE_NUM};
    wire logic [15:0] udcValAddr = stage_counter_pkg::VALUE_WORD_BASE + {8'h00, UDC_NUM};
    wire logic [15:0] doneWordAddr = stage_counter_pkg::DONE_WORD_BASE + {12'h000, STAGE_NUM[7:4]};
    wire logic [15:0] doneWord = (16'h0001 << STAGE_NUM[3:0]) & {16{stageDone_q}}
        | (16'h0001 << UDC_NUM[3:0]) & {16{udcDone_q && UDC_NUM[7:4] == STAGE_NUM[7:4]}};
    wire logic [31:0] statusWord = (32'h0000_0001 << stage_counter_pkg::STATUS_STAGE_BIT)
        & {32{stageDone_q}} | (32'h0000_0001 << stage_counter_pkg::STATUS_UDC_BIT)
        & {32{udcDone_q}};

    logic [31:0] readMux;
    always_comb begin
        unique case (aOff)
            stage_counter_pkg::ADDR_CTRL: readMux = {25'h000_0000, ctrl_q};
            stage_counter_pkg::ADDR_STAGE_PRESET_K: readMux = {16'h0000, stagePresetK_q};
            stage_counter_pkg::ADDR_STAGE_PRESET_V: readMux = {16'h0000, stagePresetV_q};
            stage_counter_pkg::ADDR_UDC_PRESET_K: readMux = udcPresetK_q;
            stage_counter_pkg::ADDR_UDC_PRESET_V: readMux = udcPresetV_q;
            stage_counter_pkg::ADDR_STAGE_VALUE: readMux = {16'h0000, stageVal_q};
            stage_counter_pkg::ADDR_UDC_VALUE: readMux = udcVal_q;
            stage_counter_pkg::ADDR_STATUS: readMux = statusWord;
            stage_counter_pkg::ADDR_DONE_WORD: readMux = {doneWordAddr, doneWord};
            stage_counter_pkg::ADDR_STAGE_LOC: readMux = {doneWordAddr, stageValAddr};
            stage_counter_pkg::ADDR_UDC_LOC: readMux = {udcValAddr + 16'h0001, udcValAddr};
            default: readMux = stage_counter_pkg::READ_ZERO;
        endcase
    end

    // zero-wait slave: read data is latched at the address phase
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            hrdata_q <= stage_counter_pkg::READ_ZERO;
            hreadyout_q <= 1'b0;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            if (takeAddr && !hwrite && inMap) begin
                hrdata_q <= readMux;
            end else if (takeAddr) begin
                hrdata_q <= stage_counter_pkg::READ_ZERO;
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign stageDone = stageDone_q;
    assign udcDone = udcDone_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstN);

    a_stage_hold_max: assert property (stageAtMax && !stageClr |=> stageAtMax)
        else $error("stage value left its maximum without clear");
    a_stage_clear_zero: assert property (stageClr |=> stageVal_q == 16'h0000 && !stageDone_q)
        else $error("stage clear did not zero value and done");
    a_stage_done_sticky: assert property (stageDone_q && !stageClr |=> stageDone_q)
        else $error("stage done dropped without clear");
    a_stage_count_one: assert property (stageRise && !stageAtMax && !stageClr
        |=> stageVal_q == $past(stageInc))
        else $error("stage edge did not add one");
    a_stage_gate_prev: assert property (scan && !stageActivePrev_q && !stageClr
        |=> $stable(stageVal_q))
        else $error("stage counted without active previous scan");
    a_stage_hold_idle: assert property (!scan && !stageClr |=> $stable(stageVal_q))
        else $error("stage value changed without scan");
    a_udc_reset_level: assert property (scan && ctrl_q.udcReset |=> udcVal_q == 32'h0000_0000)
        else $error("up/down reset did not zero value");
    a_udc_both_on: assert property (scan && ctrl_q.upIn && ctrl_q.downIn
        && !ctrl_q.udcReset |=> $stable(udcVal_q))
        else $error("up/down counted with both inputs on");
    a_udc_range_max: assert property (udcVal_q <= stage_counter_pkg::UDC_MAX)
        else $error("up/down value out of range");
    a_udc_zero_floor: assert property (udcAtZero && !upRise |=> udcAtZero)
        else $error("up/down value went below zero");
    // flops loaded at the release edge have no meaningful past yet
    a_udc_done_ge: assert property ($past(rstN) |-> udcDone_q == $past(udcGe))
        else $error("up/down done does not follow comparison");
    a_bus_ready: assert property ($past(rstN) |-> hreadyout_q && !hresp_q)
        else $error("slave not ready or not okay");
    a_udc_up_step: assert property (upRise && !udcAtMax && !ctrl_q.udcReset
        |=> udcVal_q == $past(udcInc))
        else $error("up/down up edge did not add one");
    a_udc_down_step: assert property (downRise && !udcAtZero && !ctrl_q.udcReset
        |=> udcVal_q == $past(udcDec))
        else $error("up/down down edge did not subtract one");

    c_stage_max: cover property (stageRise && stageAtMax);
    c_stage_done: cover property (!stageDone_q ##1 stageDone_q);
    c_udc_down: cover property (downRise && !udcAtZero);
    c_udc_done: cover property (!udcDone_q ##1 udcDone_q);

endmodule : stage_updown_counters

`default_nettype wire

// *** testbench/ahb_program_master.sv ***
// AHB-Lite master model standing in for the ladder program that drives the counters
`timescale 1ns/1ns
`default_nettype none

module ahb_program_master (
    // clock
    input wire logic mclk,
    // bus answer
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // one single word transfer; ok drops if the slave never answers
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        ok = 1'b1;
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        ok = (hready === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : ~hwdata;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        ok = ok & (hready === 1'b1);
        q = hrdata;
        // released data must not keep looking valid
        hwdata <= ~hwdata;
    endtask : xfer
endmodule : ahb_program_master

`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the stage and up/down counter block
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam logic [7:0] STAGE_N = 8'h17;
    localparam logic [7:0] UDC_N = 8'h05;
    localparam logic [31:0] IN_STAGE = 32'h0000_0001;
    localparam logic [31:0] IN_ACT = 32'h0000_0002;
    localparam logic [31:0] IN_UP = 32'h0000_0004;
    localparam logic [31:0] IN_DOWN = 32'h0000_0008;
    localparam logic [31:0] IN_RST = 32'h0000_0010;
    localparam logic [31:0] IN_SPV = 32'h0000_0020;
    localparam logic [31:0] IN_UDV = 32'h0000_0040;

    logic mclk;
    logic arst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic stageDone;
    logic udcDone;
    int failCount;
    int checked;

    stage_updown_counters #(.STAGE_NUM(STAGE_N), .UDC_NUM(UDC_N)) DUT (
        .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .stageDone(stageDone), .udcDone(udcDone));

    ahb_program_master master (
        .mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // done outputs follow the value one edge later; look once that edge has passed
    task automatic check_flag(input logic isUdc, input logic exp);
        repeat (2) @(negedge mclk);
        check({31'h0000_0000, isUdc ? udcDone : stageDone}, {31'h0000_0000, exp});
    endtask : check_flag

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic ok;
        master.xfer(1'b1, a, d, q, ok);
        if (ok !== 1'b1) begin
            failCount++;
            finish_test();
        end
    endtask : wr

    task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic ok;
        master.xfer(1'b0, a, 32'h0000_0000, q, ok);
        if (ok !== 1'b1) begin
            failCount++;
            finish_test();
        end else begin
            check(q, exp);
        end
    endtask : expect_rd

    // one controller scan: program inputs first, then the scan strobe
    task automatic scan(input logic [31:0] c);
        wr(stage_counter_pkg::ADDR_CTRL, c);
        wr(stage_counter_pkg::ADDR_SCAN, 32'h0000_0001);
    endtask : scan

    task automatic pulse(input logic [31:0] base, input logic [31:0] mask, input int n);
        repeat (n) begin
            scan(base | mask);
            scan(base);
        end
    endtask : pulse

    task automatic test_reset();
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0000);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0000);
        // zero value against zero preset already counts as done
        expect_rd(stage_counter_pkg::ADDR_STATUS, 32'h0000_0003);
        wr(8'h40, 32'hFFFF_FFFF);
        expect_rd(8'h40, 32'h0000_0000);
        expect_rd(stage_counter_pkg::ADDR_STAGE_LOC, {stage_counter_pkg::DONE_WORD_BASE
            + {12'h000, STAGE_N[7:4]}, stage_counter_pkg::VALUE_WORD_BASE + 16'(STAGE_N)});
        expect_rd(stage_counter_pkg::ADDR_UDC_LOC, {stage_counter_pkg::VALUE_WORD_BASE
            + 16'(UDC_N) + 16'h0001, stage_counter_pkg::VALUE_WORD_BASE + 16'(UDC_N)});
        $display("test reset finished");
    endtask : test_reset

    task automatic test_stage();
        wr(stage_counter_pkg::ADDR_STAGE_PRESET_K, 32'h0000_0003);
        wr(stage_counter_pkg::ADDR_STAGE_CLR, 32'h0000_0001);
        check_flag(1'b0, 1'b0);
        scan(IN_ACT);
        pulse(IN_ACT, IN_STAGE, 2);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0002);
        check_flag(1'b0, 1'b0);
        // input held on across two scans is a single edge
        scan(IN_ACT | IN_STAGE);
        scan(IN_ACT | IN_STAGE);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0003);
        check_flag(1'b0, 1'b1);
        expect_rd(stage_counter_pkg::ADDR_DONE_WORD, {stage_counter_pkg::DONE_WORD_BASE
            + {12'h000, STAGE_N[7:4]}, 16'h0001 << STAGE_N[3:0]});
        wr(stage_counter_pkg::ADDR_STAGE_PRESET_K, 32'h0000_0012);
        scan(IN_ACT);
        pulse(IN_ACT, IN_STAGE, 7);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0010);
        check_flag(1'b0, 1'b1);
        repeat (5) @(posedge mclk);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0010);
        wr(stage_counter_pkg::ADDR_STAGE_CLR, 32'h0000_0001);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0000);
        check_flag(1'b0, 1'b0);
        $display("test stage finished");
    endtask : test_stage

    task automatic test_gate();
        scan(32'h0000_0000);
        // stage entered in the same scan as the input rises: no edge
        scan(IN_ACT | IN_STAGE);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0000);
        scan(IN_ACT);
        scan(IN_ACT | IN_STAGE);
        expect_rd(stage_counter_pkg::ADDR_STAGE_VALUE, 32'h0000_0001);
        $display("test gate finished");
    endtask : test_gate

    task automatic test_preset_src();
        wr(stage_counter_pkg::ADDR_STAGE_CLR, 32'h0000_0001);
        wr(stage_counter_pkg::ADDR_STAGE_PRESET_K, 32'h0000_9999);
        wr(stage_counter_pkg::ADDR_STAGE_PRESET_V, 32'h0000_0001);
        scan(IN_ACT);
        scan(IN_ACT | IN_STAGE);
        check_flag(1'b0, 1'b0);
        wr(stage_counter_pkg::ADDR_STAGE_CLR, 32'h0000_0001);
        scan(IN_ACT | IN_SPV);
        scan(IN_ACT | IN_SPV | IN_STAGE);
        check_flag(1'b0, 1'b1);
        $display("test preset source finished");
    endtask : test_preset_src

    task automatic test_udc();
        wr(stage_counter_pkg::ADDR_UDC_PRESET_K, 32'h0000_0003);
        scan(IN_RST);
        scan(IN_RST | IN_UP);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0000);
        check_flag(1'b1, 1'b0);
        scan(32'h0000_0000);
        pulse(32'h0000_0000, IN_UP, 3);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0003);
        check_flag(1'b1, 1'b1);
        scan(IN_UP);
        scan(IN_UP | IN_DOWN);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0004);
        scan(32'h0000_0000);
        pulse(32'h0000_0000, IN_UP, 6);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0010);
        scan(IN_DOWN);
        scan(IN_DOWN | IN_UP);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0009);
        scan(IN_RST);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0000);
        check_flag(1'b1, 1'b0);
        scan(32'h0000_0000);
        pulse(32'h0000_0000, IN_DOWN, 1);
        expect_rd(stage_counter_pkg::ADDR_UDC_VALUE, 32'h0000_0000);
        wr(stage_counter_pkg::ADDR_UDC_PRESET_K, 32'h9999_9999);
        wr(stage_counter_pkg::ADDR_UDC_PRESET_V, 32'h0000_0001);
        pulse(IN_UDV, IN_UP, 1);
        check_flag(1'b1, 1'b1);
        scan(32'h0000_0000);
        check_flag(1'b1, 1'b0);
        $display("test up/down finished");
    endtask : test_udc

    initial begin
        failCount = 0;
        checked = 0;
        arst_n = 1'b0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        test_reset();
        test_stage();
        test_gate();
        test_preset_src();
        test_udc();
        finish_test();
    end
endmodule : tb

`default_nettype wire
